// ===== src/ssf_params.svh
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SSF_OFS_STATUS   8'h00
`define SSF_OFS_BITRATE  8'h04
`define SSF_OFS_CONTROL  8'h08
`define SSF_OFS_RXDATA   8'h0C
`define SSF_OFS_TXDATA   8'h10

// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define SSF_ST_TXE       7
`define SSF_ST_RXF       6
`define SSF_ST_OVR       5
`define SSF_ST_FRM       4
`define SSF_ST_PAR       3
`define SSF_ST_TXEND     2
`define SSF_ST_MPRX      1
`define SSF_ST_MPTX      0
`define SSF_CLEARABLE    8'hF8
`define SSF_STATUS_RESET 8'h84

// ----------------------------------------------------------------
// control bit positions
// ----------------------------------------------------------------
`define SSF_CT_RXEN      0
`define SSF_CT_TXEN      1
`define SSF_CT_SYNC      2
`define SSF_CT_PAR_EN    3
`define SSF_CT_PAR_ODD   4
`define SSF_CT_STOP2     5
`define SSF_CT_MP        6
`define SSF_CT_CKS_LO    8
`define SSF_CT_CKS_HI    9
`define SSF_CONTROL_RESET 10'h000

// ----------------------------------------------------------------
// bit-rate and timing
// ----------------------------------------------------------------
`define SSF_BITRATE_RESET 8'hFF
`define SSF_PRE_DIV1     6'h00
`define SSF_PRE_DIV4     6'h03
`define SSF_PRE_DIV16    6'h0F
`define SSF_PRE_DIV64    6'h3F
`define SSF_MID_SAMPLE   4'h7
`define SSF_LAST_SAMPLE  4'hF
`define SSF_LAST_BIT     3'h7

`endif

// ===== src/ssf_pkg.sv
`include "ssf_params.svh"

package ssf_pkg;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'h0,
		RX_START  = 3'h1,
		RX_DATA   = 3'h3,
		RX_PARITY = 3'h2,
		RX_MPBIT  = 3'h6,
		RX_STOP   = 3'h7
	} ssf_rx_state_t;

	typedef enum logic [2:0] {
		TX_IDLE   = 3'h0,
		TX_START  = 3'h1,
		TX_DATA   = 3'h3,
		TX_PARITY = 3'h2,
		TX_MPBIT  = 3'h6,
		TX_STOP   = 3'h7,
		TX_STOP2  = 3'h5
	} ssf_tx_state_t;

	typedef enum logic [2:0] {
		SEL_STATUS  = 3'h0,
		SEL_BITRATE = 3'h1,
		SEL_CONTROL = 3'h2,
		SEL_RXDATA  = 3'h3,
		SEL_TXDATA  = 3'h4,
		SEL_NONE    = 3'h5
	} ssf_sel_t;

	typedef struct packed {
		logic [5:0] pre;
		logic [7:0] div;
		logic       half;
		logic       tick;
	} ssf_rate_t;

	typedef struct packed {
		logic [9:0]    ctrl;
		logic [7:0]    bit_rate_divisor;
		logic [7:0]    status;
		logic [7:0]    seen;
		logic [7:0]    receive_holding_register;
		logic [7:0]    transmit_holding_register;
		ssf_rx_state_t rx_state;
		logic [3:0]    rx_cnt;
		logic [2:0]    rx_bit;
		logic [7:0]    receive_shifter;
		logic          rx_par;
		logic          rx_mp;
		ssf_tx_state_t tx_state;
		logic [3:0]    tx_cnt;
		logic [2:0]    tx_bit;
		logic [7:0]    tx_shift;
		logic          tx_par;
		logic          serial_out;
		logic          sync_clock_out;
		logic [31:0]   prdata;
		logic          pready;
		logic          pslverr;
	} ssf_state_t;

	localparam ssf_state_t SSF_STATE_RESET = '{
		ctrl:                      `SSF_CONTROL_RESET,
		bit_rate_divisor:          `SSF_BITRATE_RESET,
		status:                    `SSF_STATUS_RESET,
		rx_state:                  RX_IDLE,
		tx_state:                  TX_IDLE,
		serial_out:                1'b1,
		sync_clock_out:            1'b1,
		default:                   '0
	};

endpackage : ssf_pkg

// ===== src/ssf_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ssf_sync #(
	parameter int       WIDTH    = 1,
	parameter bit       INIT     = 1'b1
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             reset,
	// raw and filtered level
	input  wire logic [WIDTH-1:0] raw_in,
	output logic      [WIDTH-1:0] clean_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} ssf_sync_t;

	ssf_sync_t st;
	ssf_sync_t next_st;

	// ----------------------------------------------------------------
	// three stages; a change counts only once stages two and three agree
	// ----------------------------------------------------------------
	always_comb begin
		next_st    = st;
		next_st.s1 = raw_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.q[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			st <= {4 * WIDTH{INIT}};
		end else begin
			st <= next_st;
		end
	end

	assign clean_out = st.q;

endmodule : ssf_sync

`default_nettype wire

// ===== src/ssf_rate_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssf_params.svh"

module ssf_rate_gen
	import ssf_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// setting
	input  wire logic       enable,
	input  wire logic [1:0] clock_select,
	input  wire logic [7:0] divisor,
	// sixteen ticks per bit
	output logic            sample_tick
);

	ssf_rate_t st;
	ssf_rate_t next_st;
	logic [5:0] pre_mask;

	// ----------------------------------------------------------------
	// prescaler, divisor counter, halving stage
	// ----------------------------------------------------------------
	always_comb begin
		next_st      = st;
		next_st.tick = 1'b0;
		unique case (clock_select)
			2'h0: pre_mask = `SSF_PRE_DIV1;
			2'h1: pre_mask = `SSF_PRE_DIV4;
			2'h2: pre_mask = `SSF_PRE_DIV16;
			2'h3: pre_mask = `SSF_PRE_DIV64;
		endcase
		if (!enable) begin
			next_st = '0;
		end else if (st.pre >= pre_mask) begin
			next_st.pre = 6'h00;
			// a new divisor takes effect at once, even mid-count; a count already at or past it wraps
			if (st.div >= divisor) begin
				next_st.div  = 8'h00;
				next_st.half = ~st.half;
				next_st.tick = st.half;
			end else begin
				next_st.div = st.div + 8'h01;
			end
		end else begin
			next_st.pre = st.pre + 6'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sample_tick = st.tick;

endmodule : ssf_rate_gen

`default_nettype wire

// ===== src/ssf_top.sv
// Functional notes
// - Good character moved to receive holding register sets receive-full flag.
// - Framing and parity errors store the character but leave receive-full clear; receiver disable leaves both untouched.
// - Character ending while receive-full is set raises overrun; new data dropped.
// - Overrun halts reception; in clocked mode it also blocks transmission.
// - Error flags clear by read-while-set then write 0; reset and standby clear.
// - Receiver disable keeps overrun, framing and parity flags as they were.
// - Asynchronous framing error when first stop bit is 0; second unchecked.
// - Framing error still stores the character but leaves receive-full clear.
// - Framing or parity flag halts reception; clocked mode also blocks transmit.
// - Parity flag set when ones count mismatches selected even or odd parity.
// - Parity error stores the character without setting receive-full.
// - Transmit-end set by reset, standby, transmit disable, or empty at last bit.
// - Transmit-end cleared by empty-flag read-then-clear or transmit holding write.
// - Received multiprocessor bit captured in async multiprocessor format; held on disable.
// - Transmit multiprocessor bit used only in async multiprocessor transmission.
// - Eight-bit divisor with clock select sets bit rate; always readable, writable.
// - Divisor resets to all ones on reset or standby; manual reset keeps it.
// - Each channel instance owns an independent rate generator and divisor.
// - Clock select picks peripheral clock divided by 1, 4, 16 or 64.
// - Bit rate equals clock over 64 times 2^(2n-1) times (divisor plus 1).
// - Writes can only clear the flag bits; writing 1 to them does nothing; the transmit multiprocessor bit takes the written value.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ssf_params.svh"

module ssf_top
	import ssf_pkg::*;
(
	// clock and resets
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        standby,
	input  wire logic        manual_reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial line
	input  wire logic        serial_in,
	output logic             serial_out,
	output logic             sync_clock_out
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic ssf_sel_t decode(input logic [7:0] addr);
		unique case (addr)
			`SSF_OFS_STATUS:  decode = SEL_STATUS;
			`SSF_OFS_BITRATE: decode = SEL_BITRATE;
			`SSF_OFS_CONTROL: decode = SEL_CONTROL;
			`SSF_OFS_RXDATA:  decode = SEL_RXDATA;
			`SSF_OFS_TXDATA:  decode = SEL_TXDATA;
			default:          decode = SEL_NONE;
		endcase
	endfunction : decode

	ssf_state_t st;
	ssf_state_t next_st;
	ssf_sel_t   sel;
	logic       sample_tick;
	logic       rx_pin;
	logic       access;
	logic       commit;
	logic       halt;
	logic       sync_mode;
	logic       tx_block;
	logic       rx_done;
	logic       rx_stop;
	logic       tx_done;
	logic       frame_err;
	logic       par_err;
	logic [7:0] clear_mask;
	logic [3:0] clk_cnt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	ssf_sync #(
		.WIDTH    (1),
		.INIT     (1'b1)
	) u_rx_sync (
		.clock    (clock),
		.reset    (reset),
		.raw_in   (serial_in),
		.clean_out(rx_pin)
	);

	// one generator per instance, so channels never share a divisor
	ssf_rate_gen u_rate (
		.clock       (clock),
		.reset       (reset),
		.enable      (st.ctrl[`SSF_CT_RXEN] | st.ctrl[`SSF_CT_TXEN]),
		.clock_select(st.ctrl[`SSF_CT_CKS_HI:`SSF_CT_CKS_LO]),
		.divisor     (st.bit_rate_divisor),
		.sample_tick (sample_tick)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st         = st;
		next_st.pready  = 1'b0;
		next_st.pslverr = 1'b0;
		sel        = decode(paddr);
		access     = psel & penable;
		commit     = access & st.pready;
		sync_mode  = st.ctrl[`SSF_CT_SYNC];
		halt       = st.status[`SSF_ST_OVR] | st.status[`SSF_ST_FRM] | st.status[`SSF_ST_PAR];
		tx_block   = sync_mode & halt;
		clear_mask = 8'h00;
		rx_done    = 1'b0;
		rx_stop    = 1'b1;
		tx_done    = 1'b0;
		frame_err  = 1'b0;
		par_err    = 1'b0;
		clk_cnt    = 4'h0;

		// bus answer one cycle into the access phase
		if (access && !st.pready) begin
			next_st.pready  = 1'b1;
			next_st.pslverr = (sel == SEL_NONE);
			unique case (sel)
				SEL_STATUS:  next_st.prdata = {24'h000000, st.status};
				SEL_BITRATE: next_st.prdata = {24'h000000, st.bit_rate_divisor};
				SEL_CONTROL: next_st.prdata = {22'h000000, st.ctrl};
				SEL_RXDATA:  next_st.prdata = {24'h000000, st.receive_holding_register};
				SEL_TXDATA:  next_st.prdata = {24'h000000, st.transmit_holding_register};
				SEL_NONE:    next_st.prdata = 32'h00000000;
			endcase
		end

		// read side effects
		if (commit && !pwrite) begin
			if (sel == SEL_STATUS) begin
				next_st.seen = st.seen | (st.status & `SSF_CLEARABLE);
			end
			if (sel == SEL_RXDATA) begin
				next_st.status[`SSF_ST_RXF] = 1'b0;
			end
		end

		// writes
		if (commit && pwrite) begin
			unique case (sel)
				SEL_STATUS: begin
					// only a zero over a flag seen set clears it; ones are ignored, but the transmit multiprocessor bit takes the written value
					clear_mask     = ~pwdata[7:0] & st.seen & `SSF_CLEARABLE;
					next_st.status = st.status & ~clear_mask;
					next_st.status[`SSF_ST_MPTX] = pwdata[`SSF_ST_MPTX];
					if (clear_mask[`SSF_ST_TXE]) begin
						next_st.status[`SSF_ST_TXEND] = 1'b0;
					end
				end
				SEL_BITRATE: next_st.bit_rate_divisor = pwdata[7:0];
				SEL_CONTROL: next_st.ctrl = pwdata[9:0];
				SEL_TXDATA: begin
					next_st.transmit_holding_register = pwdata[7:0];
					next_st.status[`SSF_ST_TXE]       = 1'b0;
					next_st.status[`SSF_ST_TXEND]     = 1'b0;
				end
				SEL_RXDATA, SEL_NONE: begin
				end
			endcase
		end

		// ------------------------------------------------------------
		// transmitter
		// ------------------------------------------------------------
		if (!st.ctrl[`SSF_CT_TXEN]) begin
			next_st.status[`SSF_ST_TXE]   = 1'b1;
			next_st.status[`SSF_ST_TXEND] = 1'b1;
			next_st.tx_state             = TX_IDLE;
		end else if (sample_tick) begin
			next_st.tx_cnt = st.tx_cnt + 4'h1;
			unique case (st.tx_state)
				TX_IDLE: begin
					next_st.tx_cnt = 4'h0;
					if (!st.status[`SSF_ST_TXE] && !tx_block) begin
						next_st.tx_shift             = st.transmit_holding_register;
						next_st.tx_par               = 1'b0;
						next_st.tx_bit               = 3'h0;
						next_st.status[`SSF_ST_TXE]  = 1'b1;
						next_st.tx_state             = sync_mode ? TX_DATA : TX_START;
					end
				end
				TX_START: begin
					if (st.tx_cnt == `SSF_LAST_SAMPLE) begin
						next_st.tx_state = TX_DATA;
					end
				end
				TX_DATA: begin
					if (st.tx_cnt == `SSF_LAST_SAMPLE) begin
						next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
						next_st.tx_par   = st.tx_par ^ st.tx_shift[0];
						next_st.tx_bit   = st.tx_bit + 3'h1;
						if (st.tx_bit == `SSF_LAST_BIT) begin
							if (sync_mode) begin
								tx_done = 1'b1;
							end else if (st.ctrl[`SSF_CT_PAR_EN]) begin
								next_st.tx_state = TX_PARITY;
							end else if (st.ctrl[`SSF_CT_MP]) begin
								next_st.tx_state = TX_MPBIT;
							end else begin
								next_st.tx_state = TX_STOP;
							end
						end
					end
				end
				TX_PARITY: begin
					if (st.tx_cnt == `SSF_LAST_SAMPLE) begin
						next_st.tx_state = st.ctrl[`SSF_CT_MP] ? TX_MPBIT : TX_STOP;
					end
				end
				TX_MPBIT: begin
					if (st.tx_cnt == `SSF_LAST_SAMPLE) begin
						next_st.tx_state = TX_STOP;
					end
				end
				TX_STOP: begin
					if (st.tx_cnt == `SSF_LAST_SAMPLE) begin
						if (st.ctrl[`SSF_CT_STOP2]) begin
							next_st.tx_state = TX_STOP2;
						end else begin
							tx_done = 1'b1;
						end
					end
				end
				TX_STOP2: begin
					if (st.tx_cnt == `SSF_LAST_SAMPLE) begin
						tx_done = 1'b1;
					end
				end
				default: next_st.tx_state = TX_IDLE;
			endcase
			// last bit out: end if nothing waits or transmit is blocked, else run straight on
			if (tx_done) begin
				next_st.tx_cnt = 4'h0;
				if (st.status[`SSF_ST_TXE] || tx_block) begin
					next_st.tx_state              = TX_IDLE;
					next_st.status[`SSF_ST_TXEND] = st.status[`SSF_ST_TXE];
				end else begin
					next_st.tx_shift             = st.transmit_holding_register;
					next_st.tx_par               = 1'b0;
					next_st.tx_bit               = 3'h0;
					next_st.status[`SSF_ST_TXE]  = 1'b1;
					next_st.tx_state             = sync_mode ? TX_DATA : TX_START;
				end
			end
		end

		// ------------------------------------------------------------
		// receiver
		// ------------------------------------------------------------
		// disabling or halting only stops the sequencer; flags, data stay
		if (!st.ctrl[`SSF_CT_RXEN] || halt) begin
			next_st.rx_state = RX_IDLE;
			next_st.rx_cnt   = 4'h0;
		end else if (sample_tick) begin
			next_st.rx_cnt = st.rx_cnt + 4'h1;
			unique case (st.rx_state)
				RX_IDLE: begin
					next_st.rx_cnt = 4'h0;
					next_st.rx_bit = 3'h0;
					if (sync_mode) begin
						next_st.rx_state = RX_DATA;
					end else if (!rx_pin) begin
						next_st.rx_state = RX_START;
					end
				end
				RX_START: begin
					if (st.rx_cnt == `SSF_MID_SAMPLE) begin
						next_st.rx_cnt   = 4'h0;
						next_st.rx_state = rx_pin ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (st.rx_cnt == `SSF_LAST_SAMPLE) begin
						next_st.receive_shifter = {rx_pin, st.receive_shifter[7:1]};
						next_st.rx_bit          = st.rx_bit + 3'h1;
						if (st.rx_bit == `SSF_LAST_BIT) begin
							if (sync_mode) begin
								rx_done = 1'b1;
							end else if (st.ctrl[`SSF_CT_PAR_EN]) begin
								next_st.rx_state = RX_PARITY;
							end else if (st.ctrl[`SSF_CT_MP]) begin
								next_st.rx_state = RX_MPBIT;
							end else begin
								next_st.rx_state = RX_STOP;
							end
						end
					end
				end
				RX_PARITY: begin
					if (st.rx_cnt == `SSF_LAST_SAMPLE) begin
						next_st.rx_par   = rx_pin;
						next_st.rx_state = st.ctrl[`SSF_CT_MP] ? RX_MPBIT : RX_STOP;
					end
				end
				RX_MPBIT: begin
					if (st.rx_cnt == `SSF_LAST_SAMPLE) begin
						next_st.rx_mp    = rx_pin;
						next_st.rx_state = RX_STOP;
					end
				end
				RX_STOP: begin
					// one stop bit checked; a second one is treated as idle line
					if (st.rx_cnt == `SSF_LAST_SAMPLE) begin
						rx_done = 1'b1;
						rx_stop = rx_pin;
					end
				end
				default: next_st.rx_state = RX_IDLE;
			endcase
			if (rx_done) begin
				next_st.rx_state = sync_mode ? RX_DATA : RX_IDLE;
				next_st.rx_cnt   = 4'h0;
				next_st.rx_bit   = 3'h0;
				frame_err = !sync_mode && !rx_stop;
				par_err   = !sync_mode && st.ctrl[`SSF_CT_PAR_EN]
					&& ((^{st.receive_shifter, st.rx_par}) != st.ctrl[`SSF_CT_PAR_ODD]);
				if (st.status[`SSF_ST_RXF]) begin
					next_st.status[`SSF_ST_OVR] = 1'b1;
				end else begin
					next_st.receive_holding_register = next_st.receive_shifter;
					if (!sync_mode && st.ctrl[`SSF_CT_MP]) begin
						next_st.status[`SSF_ST_MPRX] = next_st.rx_mp;
					end
					if (!frame_err && !par_err) begin
						next_st.status[`SSF_ST_RXF] = 1'b1;
					end
					next_st.status[`SSF_ST_FRM] = st.status[`SSF_ST_FRM] | frame_err;
					next_st.status[`SSF_ST_PAR] = st.status[`SSF_ST_PAR] | par_err;
				end
			end
		end

		// manual reset spares status and divisor
		if (manual_reset) begin
			next_st.ctrl     = `SSF_CONTROL_RESET;
			next_st.tx_state = TX_IDLE;
			next_st.rx_state = RX_IDLE;
			next_st.tx_cnt   = 4'h0;
			next_st.rx_cnt   = 4'h0;
		end

		// a flag set again after clearing must be read once more
		next_st.seen = next_st.seen & next_st.status;

		// ------------------------------------------------------------
		// line drivers
		// ------------------------------------------------------------
		unique case (next_st.tx_state)
			TX_IDLE:   next_st.serial_out = 1'b1;
			TX_START:  next_st.serial_out = 1'b0;
			TX_DATA:   next_st.serial_out = next_st.tx_shift[0];
			TX_PARITY: next_st.serial_out = next_st.tx_par ^ st.ctrl[`SSF_CT_PAR_ODD];
			TX_MPBIT:  next_st.serial_out = st.status[`SSF_ST_MPTX];
			TX_STOP:   next_st.serial_out = 1'b1;
			TX_STOP2:  next_st.serial_out = 1'b1;
			default:   next_st.serial_out = 1'b1;
		endcase
		// clocked mode: low in the first half of each bit, rising mid-bit
		clk_cnt = (next_st.tx_state != TX_IDLE) ? next_st.tx_cnt : next_st.rx_cnt;
		if (sync_mode && (next_st.tx_state != TX_IDLE || next_st.rx_state != RX_IDLE)) begin
			next_st.sync_clock_out = clk_cnt[3];
		end else begin
			next_st.sync_clock_out = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset || standby) begin
			st <= SSF_STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign prdata         = st.prdata;
	assign pready         = st.pready;
	assign pslverr        = st.pslverr;
	assign serial_out     = st.serial_out;
	assign sync_clock_out = st.sync_clock_out;

endmodule : ssf_top

`default_nettype wire

// ===== verification/ssf_top_properties.sv
`timescale 1ns/1ns
`default_nettype none

module ssf_top_properties (
	// clock and resets
	input wire logic        clock,
	input wire logic        reset,
	input wire logic        standby,
	input wire logic        manual_reset,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// serial line
	input wire logic        serial_in,
	input wire logic        serial_out,
	input wire logic        sync_clock_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	chk_ready_wait:
		assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("late pready");
	chk_ready_pulse:
		assert property (pready |=> !pready) else $error("pready too long");
	chk_ready_phase:
		assert property (pready |-> psel && penable && $past(penable)) else $error("stray pready");
	chk_err_unmapped:
		assert property (pready && paddr > 8'h10 |-> pslverr) else $error("no slave error");
	chk_err_mapped:
		assert property (pready && paddr[1:0] == 2'h0 && paddr <= 8'h10 |-> !pslverr)
			else $error("false slave error");
	chk_err_zero:
		assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
	chk_divisor_width:
		assert property (pready && !pwrite && paddr == 8'h04 |-> prdata[31:8] == 24'h0)
			else $error("divisor wider than 8 bits");
	chk_reset_out:
		assert property ($fell(reset) |-> serial_out && sync_clock_out && !pready && prdata == 32'h0)
			else $error("outputs after reset");
	chk_standby_out:
		assert property (standby |=> !pready && !pslverr && prdata == 32'h0)
			else $error("outputs in standby");
endmodule : ssf_top_properties

`default_nettype wire

// ===== verification/ssf_line_peer.sv
`timescale 1ns/1ns
`default_nettype none

module ssf_line_peer #(
	parameter int BIT = 32
) (
	// clock
	input wire logic clock,
	// serial line
	input wire logic line_from_dut,
	output logic     line_to_dut
);
	// the line rests at mark level between frames
	initial line_to_dut = 1'b1;

	task automatic send(input logic [7:0] d, input logic par_on, input logic par, input logic stop);
		logic [10:0] f;
		f = par_on ? {stop, par, d, 1'b0} : {1'b1, stop, d, 1'b0};
		for (int i = 0; i < (par_on ? 11 : 10); i++) begin
			line_to_dut <= f[i];
			repeat (BIT) @(posedge clock);
		end
		line_to_dut <= 1'b1;
	endtask : send

	// a missing start bit ends the wait and leaves garbage for the compare to catch
	task automatic recv(output logic [7:0] d);
		int n;
		n = 0;
		while (line_from_dut !== 1'b0 && n < 2000) begin
			@(posedge clock);
			n++;
		end
		repeat (BIT / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clock);
			d[i] = line_from_dut;
		end
	endtask : recv
endmodule : ssf_line_peer

`default_nettype wire

// ===== verification/serial_status_flags_and_bit_rate_bench.sv
`timescale 1ns/1ns
`default_nettype none

module serial_status_flags_and_bit_rate_bench;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] q; logic e;} ssf_row_t;
	logic        clock, reset, standby, manual_reset, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, b;
	logic [31:0] pwdata, prdata, q;
	logic        e, line_rx, serial_out, sync_clock_out;
	int          error_cnt = 0;
	int          compares = 0;
	int          n_low = 0;
	ssf_row_t    rows [10] = '{'{8'h00, 0, 0, 32'h84, 0}, '{8'h04, 0, 0, 32'hFF, 0},
		'{8'h04, 1, 0, 0, 0}, '{8'h04, 0, 0, 32'h00, 0}, '{8'h00, 1, 32'hFF, 0, 0},
		'{8'h00, 0, 0, 32'h85, 0}, '{8'h00, 1, 32'h84, 0, 0}, '{8'h00, 0, 0, 32'h84, 0},
		'{8'h20, 0, 0, 32'h00, 1}, '{8'h08, 1, 32'h001, 0, 0}};

	ssf_top dut (.clock(clock), .reset(reset), .standby(standby), .manual_reset(manual_reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in(line_rx),
		.serial_out(serial_out), .sync_clock_out(sync_clock_out));
	ssf_line_peer peer (.clock(clock), .line_from_dut(serial_out), .line_to_dut(line_rx));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// idle cycle at the end keeps two transfers from driving psel in one step
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(q, exp);
	endtask : rd

	task automatic rx(input logic [7:0] d, input logic par_on, input logic par, input logic stop);
		peer.send(d, par_on, par, stop);
		repeat (8) @(posedge clock);
	endtask : rx

	initial begin
		{reset, standby, manual_reset, psel, penable, pwrite, paddr, pwdata} = '0;
		reset = 1'b1;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			if (!rows[i].w) chk(q, rows[i].q);
			chk({31'h0, e}, {31'h0, rows[i].e});
		end
		$display("register rows done");
		rx(8'h5A, 0, 0, 1);
		rd(8'h00, 32'hC4);
		rd(8'h0C, 32'h5A);
		rx(8'h33, 0, 0, 1);
		rx(8'h44, 0, 0, 1);
		rd(8'h00, 32'hE4);
		apb(8'h00, 1'b1, 32'hDC);
		rd(8'h00, 32'hC4);
		rd(8'h0C, 32'h33);
		$display("overrun test done");
		rx(8'h77, 0, 0, 0);
		rd(8'h00, 32'h94);
		rd(8'h0C, 32'h77);
		rx(8'h11, 0, 0, 1);
		rd(8'h0C, 32'h77);
		apb(8'h00, 1'b1, 32'hEC);
		rd(8'h00, 32'h84);
		apb(8'h08, 1'b1, 32'h009);
		rx(8'h0F, 1, 1, 1);
		rd(8'h00, 32'h8C);
		rd(8'h0C, 32'h0F);
		apb(8'h00, 1'b1, 32'hF4);
		$display("framing and parity tests done");
		apb(8'h08, 1'b1, 32'h002);
		apb(8'h10, 1'b1, 32'hA5);
		rd(8'h00, 32'h80);
		peer.recv(b);
		chk({24'h0, b}, 32'hA5);
		// the stop bit is still on the line after the last data sample
		repeat (60) @(posedge clock);
		rd(8'h00, 32'h84);
		$display("transmit test done");
		apb(8'h08, 1'b1, 32'h041);
		// the peer's parity slot carries the multiprocessor bit here
		rx(8'h3C, 1, 1, 1);
		rd(8'h00, 32'hC6);
		rd(8'h0C, 32'h3C);
		apb(8'h08, 1'b1, 32'h000);
		rd(8'h00, 32'h86);
		apb(8'h08, 1'b1, 32'h006);
		apb(8'h10, 1'b1, 32'h3C);
		repeat (400) begin
			@(posedge clock);
			if (!sync_clock_out) n_low++;
		end
		chk(n_low, 32'h80);
		rd(8'h00, 32'h86);
		$display("multiprocessor and clocked tests done");
		apb(8'h04, 1'b1, 32'h12);
		manual_reset <= 1'b1;
		@(posedge clock);
		manual_reset <= 1'b0;
		@(posedge clock);
		rd(8'h04, 32'h12);
		standby <= 1'b1;
		@(posedge clock);
		standby <= 1'b0;
		@(posedge clock);
		rd(8'h04, 32'hFF);
		rd(8'h00, 32'h84);
		$display("reset test done");
		final_report();
	end

	initial begin
		repeat (30000) @(posedge clock);
		error_cnt++;
		final_report();
	end
endmodule : serial_status_flags_and_bit_rate_bench

bind ssf_top ssf_top_properties chk (.clock(clock), .reset(reset), .standby(standby),
	.manual_reset(manual_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serial_in(serial_in), .serial_out(serial_out), .sync_clock_out(sync_clock_out));

`default_nettype wire
